// ==== hdl/ebi_bus_ctrl.sv ====
// External parallel bus controller with hold and external DMA support
`timescale 1ns/1ns
`default_nettype none

module ebi_bus_ctrl #(
  parameter int RAM_DEPTH = ebi_pkg::RAM_DEPTH
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  // Core request port
  input wire logic req_valid,
  input wire ebi_pkg::ebi_space_t req_space,
  input wire logic req_write,
  input wire logic req_fetch,
  input wire logic [ebi_pkg::ADDR_W-1:0] req_addr,
  input wire logic [ebi_pkg::DATA_W-1:0] req_wdata,
  output logic req_done,
  output logic [ebi_pkg::DATA_W-1:0] req_rdata,
  output logic bus_busy,
  // Pin inputs
  input wire logic system_reset_n,
  input wire logic output_off_n,
  input wire logic ready,
  input wire logic hold_req_n,
  // Address and data lines
  input wire logic [ebi_pkg::ADDR_W-1:0] address_lines_i,
  output logic [ebi_pkg::ADDR_W-1:0] address_lines_o,
  output logic address_lines_oe,
  input wire logic [ebi_pkg::DATA_W-1:0] data_lines_i,
  output logic [ebi_pkg::DATA_W-1:0] data_lines_o,
  output logic data_lines_oe,
  // Space selects and strobes
  output logic program_space_sel_n,
  output logic data_space_sel_n,
  output logic io_space_sel_n,
  output logic space_sel_oe,
  output logic read_sel_n,
  output logic write_strobe_n,
  output logic rdwr_strobe_oe,
  input wire logic read_not_write_i,
  output logic read_not_write_o,
  output logic read_not_write_oe,
  input wire logic cycle_strobe_n_i,
  output logic cycle_strobe_n_o,
  output logic cycle_strobe_n_oe,
  // Multiprocessing lines
  input wire logic global_or_dma_request_n_i,
  output logic global_or_dma_request_n_o,
  output logic global_or_dma_request_n_oe,
  output logic fetch_or_dma_ack_n,
  output logic fetch_or_dma_ack_oe,
  output logic hold_granted_n,
  output logic hold_granted_oe
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [ebi_pkg::IN_W-1:0] pin_raw;
  logic [ebi_pkg::IN_W-1:0] sync_a;
  logic [ebi_pkg::IN_W-1:0] sync_b;
  logic cycle_strobe_n_prev;
  logic [ebi_pkg::SYNC_STAGES-1:0] off_sync;
  ebi_pkg::ebi_state_t state;
  ebi_pkg::ebi_state_t next_state;
  ebi_pkg::ebi_space_t cur_space;
  logic cur_write;
  logic cur_fetch;
  logic dma_rd_pending;
  logic next_done;
  logic [ebi_pkg::SYNC_STAGES-1:0] stay;

  assign pin_raw = {ready, hold_req_n, system_reset_n, global_or_dma_request_n_i,
                    cycle_strobe_n_i, read_not_write_i, address_lines_i, data_lines_i};

  // Two flops per input; first stage is read only by the second
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_a <= ebi_pkg::SYNC_RESET;
      sync_b <= ebi_pkg::SYNC_RESET;
      cycle_strobe_n_prev <= 1'b1;
      off_sync <= {ebi_pkg::SYNC_STAGES{1'b1}};
    end
    else
    begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
      cycle_strobe_n_prev <= sync_b[ebi_pkg::POS_CYCLE_STROBE_N];
      off_sync <= {off_sync[ebi_pkg::SYNC_STAGES-2:0], output_off_n};
    end
  end

  // Named views of the synchronised inputs
  wire logic s_ready = sync_b[ebi_pkg::POS_READY];
  wire logic s_hold_n = sync_b[ebi_pkg::POS_HOLD];
  wire logic s_rst_n = sync_b[ebi_pkg::POS_RST];
  wire logic s_breq_n = sync_b[ebi_pkg::POS_BREQ];
  wire logic s_cycle_strobe_n_n = sync_b[ebi_pkg::POS_CYCLE_STROBE_N];
  wire logic s_rw = sync_b[ebi_pkg::POS_RW];
  wire logic [ebi_pkg::ADDR_W-1:0] s_addr = sync_b[ebi_pkg::POS_ADDR +: ebi_pkg::ADDR_W];
  wire logic [ebi_pkg::DATA_W-1:0] s_data = sync_b[ebi_pkg::POS_DATA +: ebi_pkg::DATA_W];
  wire logic dma_cycle_strobe_n_fall = cycle_strobe_n_prev && !s_cycle_strobe_n_n;

  // ----------------------------------------------------------------
  // Single-access RAM for external DMA
  // ----------------------------------------------------------------
  ebi_ram_if ram ();

  ebi_sa_ram #(
    .DEPTH(RAM_DEPTH)
  ) u_ram (
    .sys_clk(sys_clk),
    .port(ram.ctrl)
  );

  // RAM access on each strobe from the DMA master
  assign ram.en = (state == ebi_pkg::EBI_ST_DMA) && dma_cycle_strobe_n_fall;
  assign ram.we = !s_rw;
  assign ram.addr = s_addr;
  assign ram.wdata = s_data;

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------

  // Space decode used for the three selects
  function automatic logic sel_for(input ebi_pkg::ebi_space_t sp,
                                   input ebi_pkg::ebi_space_t want);
    sel_for = !(sp == want);
  endfunction : sel_for

  // Next state; ready counts only once the synchronisers hold this cycle's pins
  always_comb
  begin
    next_state = state;
    next_done = 1'b0;
    unique case (state)
      ebi_pkg::EBI_ST_IDLE:
      begin
        if (!s_hold_n)
          next_state = ebi_pkg::EBI_ST_HOLD;
        else if (req_valid && req_space == ebi_pkg::EBI_SP_GLOBAL)
          next_state = ebi_pkg::EBI_ST_GRANT;
        else if (req_valid)
          next_state = ebi_pkg::EBI_ST_ACCESS;
      end
      ebi_pkg::EBI_ST_GRANT:
      begin
        if (s_ready && stay[ebi_pkg::SYNC_STAGES-1])
          next_state = ebi_pkg::EBI_ST_ACCESS;
      end
      ebi_pkg::EBI_ST_ACCESS:
      begin
        if (s_ready && stay[ebi_pkg::SYNC_STAGES-1])
        begin
          next_state = ebi_pkg::EBI_ST_IDLE;
          next_done = 1'b1;
        end
      end
      ebi_pkg::EBI_ST_HOLD:
      begin
        if (s_hold_n)
          next_state = ebi_pkg::EBI_ST_IDLE;
        else if (!s_breq_n)
          next_state = ebi_pkg::EBI_ST_DMA;
      end
      ebi_pkg::EBI_ST_DMA:
      begin
        if (s_hold_n)
          next_state = ebi_pkg::EBI_ST_IDLE;
        else if (s_breq_n)
          next_state = ebi_pkg::EBI_ST_HOLD;
      end
    endcase
    if (!s_rst_n)
    begin
      next_state = ebi_pkg::EBI_ST_IDLE;
      next_done = 1'b0;
    end
  end

  // State, captured request and answer
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ebi_pkg::EBI_ST_IDLE;
      cur_space <= ebi_pkg::EBI_SP_PROG;
      cur_write <= 1'b0;
      cur_fetch <= 1'b0;
      req_done <= 1'b0;
      req_rdata <= ebi_pkg::DATA_RESET;
      dma_rd_pending <= 1'b0;
      stay <= {ebi_pkg::SYNC_STAGES{1'b0}};
    end
    else
    begin
      state <= next_state;
      stay <= (next_state == state) ? {stay[ebi_pkg::SYNC_STAGES-2:0], 1'b1} :
              {ebi_pkg::SYNC_STAGES{1'b0}};
      req_done <= next_done;
      dma_rd_pending <= ram.en && !ram.we;
      if (state == ebi_pkg::EBI_ST_IDLE && req_valid)
      begin
        cur_space <= req_space;
        cur_write <= req_write;
        cur_fetch <= req_fetch;
      end
      if (next_done && !cur_write)
        req_rdata <= s_data;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive decode
  // ----------------------------------------------------------------
  logic [ebi_pkg::ADDR_W-1:0] held_addr;
  logic [ebi_pkg::DATA_W-1:0] held_wdata;
  logic [ebi_pkg::DATA_W-1:0] dma_rdata;

  wire logic off_now = !off_sync[ebi_pkg::SYNC_STAGES-1];
  wire logic in_acc = (next_state == ebi_pkg::EBI_ST_ACCESS);
  wire logic in_grant = (next_state == ebi_pkg::EBI_ST_GRANT);
  wire logic in_hold = (next_state == ebi_pkg::EBI_ST_HOLD) ||
                       (next_state == ebi_pkg::EBI_ST_DMA);
  wire logic in_dma = (next_state == ebi_pkg::EBI_ST_DMA);
  wire logic bus_drive = !off_now && !in_hold;
  wire logic dma_read_out = in_dma && s_rw && !s_cycle_strobe_n_n && !off_now;
  wire logic write_out = in_acc && acc_wr && s_rst_n && bus_drive;
  wire ebi_pkg::ebi_space_t acc_sp = (state == ebi_pkg::EBI_ST_IDLE) ? req_space : cur_space;
  wire logic acc_wr = (state == ebi_pkg::EBI_ST_IDLE) ? req_write : cur_write;
  wire logic acc_ft = (state == ebi_pkg::EBI_ST_IDLE) ? req_fetch : cur_fetch;
  wire ebi_pkg::ebi_space_t sel_sp = (acc_sp == ebi_pkg::EBI_SP_GLOBAL) ?
                                     ebi_pkg::EBI_SP_DATA : acc_sp;

  // Address and data held for the whole cycle
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      held_addr <= ebi_pkg::ADDR_RESET;
      held_wdata <= ebi_pkg::DATA_RESET;
      dma_rdata <= ebi_pkg::DATA_RESET;
    end
    else
    begin
      if (state == ebi_pkg::EBI_ST_IDLE && req_valid)
      begin
        held_addr <= req_addr;
        held_wdata <= req_wdata;
      end
      if (dma_rd_pending)
        dma_rdata <= ram.rdata;
    end
  end

  // Registered pin outputs
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      address_lines_o <= ebi_pkg::ADDR_RESET;
      address_lines_oe <= 1'b0;
      data_lines_o <= ebi_pkg::DATA_RESET;
      data_lines_oe <= 1'b0;
      program_space_sel_n <= 1'b1;
      data_space_sel_n <= 1'b1;
      io_space_sel_n <= 1'b1;
      space_sel_oe <= 1'b0;
      read_sel_n <= 1'b1;
      write_strobe_n <= 1'b1;
      rdwr_strobe_oe <= 1'b0;
      read_not_write_o <= 1'b1;
      read_not_write_oe <= 1'b0;
      cycle_strobe_n_o <= 1'b1;
      cycle_strobe_n_oe <= 1'b0;
      global_or_dma_request_n_o <= 1'b1;
      global_or_dma_request_n_oe <= 1'b0;
      fetch_or_dma_ack_n <= 1'b1;
      fetch_or_dma_ack_oe <= 1'b0;
      hold_granted_n <= 1'b1;
      hold_granted_oe <= 1'b0;
      bus_busy <= 1'b0;
    end
    else
    begin
      address_lines_o <= (state == ebi_pkg::EBI_ST_IDLE) ? req_addr : held_addr;
      address_lines_oe <= bus_drive;
      data_lines_o <= dma_read_out ? dma_rdata :
                      ((state == ebi_pkg::EBI_ST_IDLE) ? req_wdata : held_wdata);
      data_lines_oe <= write_out || dma_read_out;
      program_space_sel_n <= !in_acc || sel_for(sel_sp, ebi_pkg::EBI_SP_PROG);
      data_space_sel_n <= !in_acc || sel_for(sel_sp, ebi_pkg::EBI_SP_DATA);
      io_space_sel_n <= !in_acc || sel_for(sel_sp, ebi_pkg::EBI_SP_IO);
      space_sel_oe <= bus_drive;
      read_sel_n <= !(in_acc && !acc_wr);
      write_strobe_n <= !(in_acc && acc_wr);
      rdwr_strobe_oe <= bus_drive;
      read_not_write_o <= !(in_acc && acc_wr);
      read_not_write_oe <= bus_drive;
      cycle_strobe_n_o <= !in_acc;
      cycle_strobe_n_oe <= bus_drive;
      global_or_dma_request_n_o <= !((in_acc || in_grant) &&
                                     acc_sp == ebi_pkg::EBI_SP_GLOBAL);
      global_or_dma_request_n_oe <= bus_drive;
      fetch_or_dma_ack_n <= in_dma ? 1'b0 : !(in_acc && acc_ft);
      fetch_or_dma_ack_oe <= !off_now;
      hold_granted_n <= !in_hold;
      hold_granted_oe <= !off_now;
      bus_busy <= (next_state != ebi_pkg::EBI_ST_IDLE);
    end
  end

endmodule : ebi_bus_ctrl
`default_nettype wire

// ==== hdl/ebi_pkg.sv ====
// Constants and types shared by the external bus interface files
package ebi_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int SYNC_STAGES = 2;
  localparam int RAM_DEPTH = 1024;
  localparam int IN_W = 6 + ADDR_W + DATA_W;

  // ----------------------------------------------------------------
  // Positions of pin inputs in the synchroniser vector
  // ----------------------------------------------------------------
  localparam int POS_DATA = 0;
  localparam int POS_ADDR = DATA_W;
  localparam int POS_RW = ADDR_W + DATA_W;
  localparam int POS_CYCLE_STROBE_N = POS_RW + 1;
  localparam int POS_BREQ = POS_RW + 2;
  localparam int POS_RST = POS_RW + 3;
  localparam int POS_HOLD = POS_RW + 4;
  localparam int POS_READY = POS_RW + 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [IN_W-1:0] SYNC_RESET = {IN_W{1'b1}};
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Access spaces and controller states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EBI_SP_PROG = 2'h0,
    EBI_SP_DATA = 2'h1,
    EBI_SP_IO = 2'h2,
    EBI_SP_GLOBAL = 2'h3
  } ebi_space_t;

  typedef enum logic [4:0] {
    EBI_ST_IDLE = 5'h01,
    EBI_ST_GRANT = 5'h02,
    EBI_ST_ACCESS = 5'h04,
    EBI_ST_HOLD = 5'h08,
    EBI_ST_DMA = 5'h10
  } ebi_state_t;

endpackage : ebi_pkg

// ==== hdl/ebi_ram_if.sv ====
// Port between the bus controller and the single-access RAM
`timescale 1ns/1ns
`default_nettype none
interface ebi_ram_if;
  logic en;
  logic we;
  logic [ebi_pkg::ADDR_W-1:0] addr;
  logic [ebi_pkg::DATA_W-1:0] wdata;
  logic [ebi_pkg::DATA_W-1:0] rdata;

  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : ebi_ram_if
`default_nettype wire

// ==== hdl/ebi_sa_ram.sv ====
// On-chip single-access RAM reached by external DMA masters
`timescale 1ns/1ns
`default_nettype none
module ebi_sa_ram #(
  parameter int DEPTH = ebi_pkg::RAM_DEPTH
) (
  input wire logic sys_clk,
  ebi_ram_if.mem port
);

  logic [ebi_pkg::DATA_W-1:0] mem [DEPTH];
  logic [$clog2(DEPTH)-1:0] index;

  // Low address bits select the word; upper bits wrap
  assign index = port.addr[$clog2(DEPTH)-1:0];

  // ----------------------------------------------------------------
  // One access per enabled cycle, read data registered
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (port.en && port.we)
    begin
      mem[index] <= port.wdata;
    end
    if (port.en)
    begin
      port.rdata <= mem[index];
    end
  end

endmodule : ebi_sa_ram
`default_nettype wire

// ==== verification/ebi_bus_ctrl_chk.sv ====
// Port assertions for the external bus controller
`timescale 1ns/1ns
`default_nettype none
module ebi_bus_ctrl_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic output_off_n,
  input wire logic ready,
  input wire logic bus_busy,
  input wire logic req_done,
  input wire logic address_lines_oe,
  input wire logic data_lines_oe,
  input wire logic space_sel_oe,
  input wire logic rdwr_strobe_oe,
  input wire logic read_not_write_o,
  input wire logic read_not_write_oe,
  input wire logic cycle_strobe_n_o,
  input wire logic cycle_strobe_n_oe,
  input wire logic program_space_sel_n,
  input wire logic data_space_sel_n,
  input wire logic io_space_sel_n,
  input wire logic read_sel_n,
  input wire logic write_strobe_n,
  input wire logic fetch_or_dma_ack_n,
  input wire logic hold_granted_n
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_off_floats:
    assert property (!output_off_n |-> ##3 !(address_lines_oe | data_lines_oe | space_sel_oe |
      rdwr_strobe_oe | cycle_strobe_n_oe)) else $error("pins driven while output off");
  a_hold_floats:
    assert property (!hold_granted_n |-> !(address_lines_oe | space_sel_oe | rdwr_strobe_oe |
      read_not_write_oe | cycle_strobe_n_oe)) else $error("pins driven in hold");
  a_one_select:
    assert property ($onehot0(~{program_space_sel_n, data_space_sel_n, io_space_sel_n}))
      else $error("more than one space select low");
  a_select_cycle:
    assert property (space_sel_oe && !(program_space_sel_n & data_space_sel_n & io_space_sel_n)
      |-> !cycle_strobe_n_o) else $error("space select low outside a bus cycle");
  a_strobe_access:
    assert property (cycle_strobe_n_oe && !cycle_strobe_n_o |-> bus_busy &&
      (read_sel_n != write_strobe_n)) else $error("cycle strobe without one access strobe");
  a_dir_write:
    assert property (read_not_write_oe && !read_not_write_o |-> !write_strobe_n && data_lines_oe)
      else $error("direction low outside a write");
  a_data_drive:
    assert property (data_lines_oe |-> !write_strobe_n || !hold_granted_n)
      else $error("data lines driven without write or transfer data");
  a_ready_wait:
    assert property (!ready |-> ##3 !req_done) else $error("access ended while not ready");
  a_fetch_line:
    assert property (!fetch_or_dma_ack_n |-> !hold_granted_n || !cycle_strobe_n_o)
      else $error("fetch line low outside fetch or transfer");
endmodule : ebi_bus_ctrl_chk

bind ebi_bus_ctrl ebi_bus_ctrl_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .output_off_n(output_off_n), .ready(ready), .bus_busy(bus_busy), .req_done(req_done),
  .address_lines_oe(address_lines_oe), .data_lines_oe(data_lines_oe),
  .space_sel_oe(space_sel_oe), .rdwr_strobe_oe(rdwr_strobe_oe),
  .read_not_write_o(read_not_write_o), .read_not_write_oe(read_not_write_oe),
  .cycle_strobe_n_o(cycle_strobe_n_o), .cycle_strobe_n_oe(cycle_strobe_n_oe),
  .program_space_sel_n(program_space_sel_n), .data_space_sel_n(data_space_sel_n),
  .io_space_sel_n(io_space_sel_n), .read_sel_n(read_sel_n), .write_strobe_n(write_strobe_n),
  .fetch_or_dma_ack_n(fetch_or_dma_ack_n), .hold_granted_n(hold_granted_n));
`default_nettype wire

// ==== verification/ebi_ext_mem.sv ====
// External memory and ready responder on the far side of the bus
`timescale 1ns/1ns
`default_nettype none
module ebi_ext_mem (
  input wire logic sys_clk,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic strobe_n,
  input wire logic greq_n,
  input wire logic [1:0] wait_n,
  output logic ready,
  output logic drive,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:255];
  logic [2:0] cnt;
  logic act;
  initial foreach (mem[i]) mem[i] = 16'h0000;
  // Ready and grant only after the programmed wait of this cycle
  assign act = !strobe_n || !greq_n;
  assign ready = act && (cnt >= {1'b0, wait_n});
  // Read data is put out only while read select is low
  assign drive = !rd_n;
  assign rdata = mem[addr[7:0]];
  // Count cycles of the access and store write data
  always @(posedge sys_clk)
  begin
    cnt <= act ? cnt + {2'h0, cnt != 3'h7} : 3'h0;
    if (!wr_n)
      mem[addr[7:0]] <= wdata;
  end
endmodule : ebi_ext_mem
`default_nettype wire

// ==== verification/ebi_bus_ctrl_tb.sv ====
// Self-checking bench for the external bus controller
`timescale 1ns/1ns
`default_nettype none
module ebi_bus_ctrl_tb;
  logic sys_clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_fetch = 1'b0;
  logic system_reset_n = 1'b1, output_off_n = 1'b1, hold_req_n = 1'b1, ready, req_done;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, req_rdata, last = 16'h0000;
  logic [15:0] address_lines_i, address_lines_o, data_lines_i, data_lines_o, mem_q;
  logic [15:0] dma_a = 16'h0000, dma_d = 16'h0000;
  logic dma_rw = 1'b1, dma_stb_n = 1'b1, dma_req_n = 1'b1, dma_drv = 1'b0, mem_drv;
  logic [1:0] wait_n = 2'h0;
  ebi_pkg::ebi_space_t req_space = ebi_pkg::EBI_SP_PROG;
  logic bus_busy, address_lines_oe, data_lines_oe, program_space_sel_n, data_space_sel_n;
  logic io_space_sel_n, space_sel_oe, read_sel_n, write_strobe_n, rdwr_strobe_oe;
  logic read_not_write_i, read_not_write_o, read_not_write_oe, cycle_strobe_n_i;
  logic cycle_strobe_n_o, cycle_strobe_n_oe, global_or_dma_request_n_i, fetch_or_dma_ack_n;
  logic global_or_dma_request_n_o, global_or_dma_request_n_oe, fetch_or_dma_ack_oe;
  logic hold_granted_n, hold_granted_oe;
  logic [15:0] model [0:255];
  int miscompares = 0, comparisons = 0, cyc = 0;

  // Resolve shared pins; a released data bus shows a changing pattern
  assign data_lines_i = data_lines_oe ? data_lines_o : mem_drv ? mem_q : dma_drv ? dma_d : ~last;
  assign address_lines_i = address_lines_oe ? address_lines_o : dma_a;
  assign read_not_write_i = read_not_write_oe ? read_not_write_o : dma_rw;
  assign cycle_strobe_n_i = cycle_strobe_n_oe ? cycle_strobe_n_o : dma_stb_n;
  assign global_or_dma_request_n_i = global_or_dma_request_n_oe ? global_or_dma_request_n_o :
    dma_req_n;

  ebi_bus_ctrl u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_space(req_space), .req_write(req_write), .req_fetch(req_fetch),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_done(req_done), .req_rdata(req_rdata),
    .bus_busy(bus_busy), .system_reset_n(system_reset_n), .output_off_n(output_off_n),
    .ready(ready), .hold_req_n(hold_req_n), .address_lines_i(address_lines_i),
    .address_lines_o(address_lines_o), .address_lines_oe(address_lines_oe),
    .data_lines_i(data_lines_i), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
    .program_space_sel_n(program_space_sel_n), .data_space_sel_n(data_space_sel_n),
    .io_space_sel_n(io_space_sel_n), .space_sel_oe(space_sel_oe), .read_sel_n(read_sel_n),
    .write_strobe_n(write_strobe_n), .rdwr_strobe_oe(rdwr_strobe_oe),
    .read_not_write_i(read_not_write_i), .read_not_write_o(read_not_write_o),
    .read_not_write_oe(read_not_write_oe), .cycle_strobe_n_i(cycle_strobe_n_i),
    .cycle_strobe_n_o(cycle_strobe_n_o), .cycle_strobe_n_oe(cycle_strobe_n_oe),
    .global_or_dma_request_n_i(global_or_dma_request_n_i),
    .global_or_dma_request_n_o(global_or_dma_request_n_o),
    .global_or_dma_request_n_oe(global_or_dma_request_n_oe),
    .fetch_or_dma_ack_n(fetch_or_dma_ack_n), .fetch_or_dma_ack_oe(fetch_or_dma_ack_oe),
    .hold_granted_n(hold_granted_n), .hold_granted_oe(hold_granted_oe));
  ebi_ext_mem u_mem (.sys_clk(sys_clk), .addr(address_lines_o), .wdata(data_lines_o),
    .rd_n(read_sel_n), .wr_n(write_strobe_n), .strobe_n(cycle_strobe_n_o),
    .greq_n(global_or_dma_request_n_o), .wait_n(wait_n), .ready(ready), .drive(mem_drv),
    .rdata(mem_q));

  // Clock, bus history and hang guard
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    last <= data_lines_i;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Expected {program, data, io} selects for a space
  function automatic logic [15:0] sel_exp(input logic [1:0] sp);
    return (sp == 2'h0) ? 16'h0003 : (sp == 2'h2) ? 16'h0006 : 16'h0005;
  endfunction : sel_exp

  task automatic access(input logic [1:0] sp, input logic wr, input logic [15:0] a,
    input logic [15:0] d);
    int n;
    @(posedge sys_clk) #1;
    req_valid = 1'b1;
    req_space = ebi_pkg::ebi_space_t'(sp);
    req_write = wr;
    req_fetch = (sp == 2'h0) && !wr;
    req_addr = a;
    req_wdata = d;
    @(posedge sys_clk) #1;
    req_valid = 1'b0;
    n = 0;
    while (req_done !== 1'b1 && n < 40)
    begin
      if (cycle_strobe_n_o === 1'b0)
      begin
        check("selects", 16'({program_space_sel_n, data_space_sel_n, io_space_sel_n}),
          sel_exp(sp));
        check("address", address_lines_o, a);
        check("direction", 16'(read_not_write_o), 16'(!wr));
        check("read select", 16'(read_sel_n), 16'(wr));
        check("write strobe", 16'(write_strobe_n), 16'(!wr));
        check("data drive", 16'(data_lines_oe), 16'(wr));
        check("fetch line", 16'(fetch_or_dma_ack_n), 16'(!(sp == 2'h0 && !wr)));
        check("request line", 16'(global_or_dma_request_n_o), 16'(sp != 2'h3));
        check("pin drive", 16'({address_lines_oe, space_sel_oe, rdwr_strobe_oe,
          read_not_write_oe, cycle_strobe_n_oe}), 16'h001f);
        if (wr)
          check("write data", data_lines_o, d);
      end
      @(posedge sys_clk) #1;
      n++;
    end
    check("done", 16'(req_done), 16'h0001);
    if (!wr)
      check("read data", req_rdata, model[a[7:0]]);
    else
      model[a[7:0]] = d;
  endtask : access

  task automatic dma_cycle(input logic rw, input logic [15:0] a, input logic [15:0] d);
    dma_rw = rw;
    dma_a = a;
    dma_d = d;
    dma_drv = !rw;
    @(posedge sys_clk) #1;
    dma_stb_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 if (rw) check("dma read", data_lines_oe ? data_lines_o : ~d, d);
    dma_stb_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 dma_drv = 1'b0;
  endtask : dma_cycle

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h4afbf7ef));
    foreach (model[i]) model[i] = 16'h0000;
    repeat (8) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    // Every space, each with its own wait (wait equals space), write then read back
    for (int s = 0; s < 4; s++)
    begin
      wait_n = 2'(s);
      access(2'(s), 1'b1, 16'h00f0 + 16'(s), 16'hffff - 16'(s));
      access(2'(s), 1'b0, 16'h00f0 + 16'(s), 16'h0000);
    end
    $display("test spaces done");
    repeat (40)
    begin
      wait_n = 2'($urandom_range(3));
      access(2'($urandom_range(3)), 1'($urandom_range(1)), 16'($urandom), 16'($urandom));
    end
    $display("test random done");
    output_off_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 check("off oe", 16'({address_lines_oe, data_lines_oe, space_sel_oe, cycle_strobe_n_oe,
      rdwr_strobe_oe, read_not_write_oe, global_or_dma_request_n_oe, fetch_or_dma_ack_oe,
      hold_granted_oe}), 16'h0000);
    output_off_n = 1'b1;
    $display("test output off done");
    hold_req_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 check("hold", 16'({hold_granted_n, address_lines_oe}), 16'h0000);
    dma_req_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 check("dma ack", 16'(fetch_or_dma_ack_n), 16'h0000);
    dma_cycle(1'b0, 16'h0012, 16'h5a3c);
    dma_cycle(1'b1, 16'h0012, 16'h5a3c);
    dma_req_n = 1'b1;
    hold_req_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    $display("test hold and transfer done");
    access(2'h1, 1'b1, 16'h0033, 16'h0f0f);
    // Start a slow write, then pull the reset pin while it is under way
    wait_n = 2'h3;
    @(posedge sys_clk) #1;
    req_valid = 1'b1;
    req_write = 1'b1;
    req_addr = 16'h0044;
    @(posedge sys_clk) #1;
    req_valid = 1'b0;
    check("write drive", 16'(data_lines_oe), 16'h0001);
    system_reset_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 check("pin reset", 16'({data_lines_oe, bus_busy}), 16'h0000);
    system_reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    access(2'h1, 1'b0, 16'h0033, 16'h0000);
    $display("test pin reset done");
    stop_test();
  end
endmodule : ebi_bus_ctrl_tb
`default_nettype wire
